// [core/wpf_ind_if.sv]
// Interface between the register bank and the wake indicator
`default_nettype none
interface wpf_ind_if;
  logic trigger;
  logic levelMode;
  logic [1:0] pulseSel;
  logic levelClear;
  logic wakePin;
  modport ctrl(output trigger, output levelMode, output pulseSel,
    output levelClear, input wakePin);
  modport ind(input trigger, input levelMode, input pulseSel,
    input levelClear, output wakePin);
endinterface
`default_nettype wire

// [core/wpf_indicator.sv]
// Wake indication output: pulse or held level
`default_nettype none
module wpf_indicator (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control from the register bank
  wpf_ind_if.ind ind
);
  logic [6:0] pulseCnt;
  logic [6:0] next_pulseCnt;
  logic level;
  logic next_level;
  logic pin;

  function automatic logic [6:0] pulseLen(input logic [1:0] sel);
    unique case (sel)
      2'h0: pulseLen = wpf_pkg::PULSE_CYC0;
      2'h1: pulseLen = wpf_pkg::PULSE_CYC1;
      2'h2: pulseLen = wpf_pkg::PULSE_CYC2;
      2'h3: pulseLen = wpf_pkg::PULSE_CYC3;
    endcase
  endfunction

  // A new event during a pulse is dropped, so each pulse has full length
  always_comb begin
    next_pulseCnt = pulseCnt;
    if (ind.trigger && !ind.levelMode &&
        pulseCnt == wpf_pkg::PULSE_IDLE) begin
      next_pulseCnt = pulseLen(ind.pulseSel);
    end else if (pulseCnt != wpf_pkg::PULSE_IDLE) begin
      next_pulseCnt = pulseCnt - 7'h01;
    end
  end

  // Set wins over a clear in the same cycle
  always_comb begin
    next_level = level;
    if (ind.trigger && ind.levelMode) begin
      next_level = 1'b1;
    end else if (ind.levelClear) begin
      next_level = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pulseCnt <= wpf_pkg::PULSE_IDLE;
      level <= 1'b0;
      pin <= 1'b0;
    end else begin
      pulseCnt <= next_pulseCnt;
      level <= next_level;
      pin <= ind.levelMode ? next_level :
        (next_pulseCnt != wpf_pkg::PULSE_IDLE);
    end
  end

  assign ind.wakePin = pin;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_pulse_short: assert property (
    $rose(pin) && !ind.levelMode && $past(ind.pulseSel) == 2'h0
    |-> pin [*7] ##1 !pin)
    else $error("shortest wake pulse not 7 cycles");

  chk_level_clear: assert property (
    ind.levelMode && ind.levelClear && !ind.trigger |=> !pin)
    else $error("level clear did not drop wake level");

  chk_level_hold: assert property (
    ind.levelMode && $past(ind.levelMode) && pin && !ind.levelClear
    |=> pin)
    else $error("wake level dropped without a clear");

  cov_pulse: cover property ($rose(pin) && !ind.levelMode);
  cov_level: cover property (ind.levelMode && pin ##1 !pin);
endmodule
`default_nettype wire

// [core/wpf_pkg.sv]
// Constants shared by the wake packet filter register bank
`default_nettype none
package wpf_pkg;
  // Register offsets
  localparam logic [15:0] CFG_ADDR = 16'h04A0;
  localparam logic [15:0] STS_ADDR = 16'h04A1;
  localparam logic [15:0] MAD1_ADDR = 16'h04A2;

  // Values after reset
  localparam logic [15:0] CFG_RESET = 16'h1081;
  localparam logic [15:0] STS_RESET = 16'h1000;
  localparam logic [15:0] MAD1_RESET = 16'h0000;
  localparam logic [15:0] RD_RESET = 16'h0000;

  // Config field positions
  localparam int CFG_CRC_GATE = 12;
  localparam int CFG_LVL_CLR = 11;
  localparam int CFG_PSEL_HI = 10;
  localparam int CFG_PSEL_LO = 9;
  localparam int CFG_STYLE = 8;
  localparam int CFG_DETECT = 7;
  localparam int CFG_MASK_FLAG = 6;
  localparam int CFG_SECURE = 5;
  localparam int CFG_IRQ_ON = 0;

  // Status field positions
  localparam int STS_ROUTE = 12;
  localparam int STS_SFD = 7;
  localparam int STS_CRC = 6;
  localparam int STS_PWD = 5;
  localparam int STS_SEEN = 0;

  // Sticky flag indices
  localparam int FLAG_SEEN = 0;
  localparam int FLAG_PWD = 1;
  localparam int FLAG_CRC = 2;
  localparam int FLAG_SFD = 3;
  localparam int FLAG_COUNT = 4;

  // Pulse lengths in reference clock cycles, and clock rates
  localparam int REF_CLK_MHZ = 125;
  localparam int SYS_CLK_MHZ = 100;
  localparam int PULSE_REF_CYC0 = 8;
  localparam int PULSE_REF_CYC1 = 16;
  localparam int PULSE_REF_CYC2 = 32;
  localparam int PULSE_REF_CYC3 = 64;

  // Least times: round up to whole system clock cycles
  localparam logic [6:0] PULSE_CYC0 = 7'((PULSE_REF_CYC0 * SYS_CLK_MHZ
    + REF_CLK_MHZ - 1) / REF_CLK_MHZ);
  localparam logic [6:0] PULSE_CYC1 = 7'((PULSE_REF_CYC1 * SYS_CLK_MHZ
    + REF_CLK_MHZ - 1) / REF_CLK_MHZ);
  localparam logic [6:0] PULSE_CYC2 = 7'((PULSE_REF_CYC2 * SYS_CLK_MHZ
    + REF_CLK_MHZ - 1) / REF_CLK_MHZ);
  localparam logic [6:0] PULSE_CYC3 = 7'((PULSE_REF_CYC3 * SYS_CLK_MHZ
    + REF_CLK_MHZ - 1) / REF_CLK_MHZ);
  localparam logic [6:0] PULSE_IDLE = 7'h00;
endpackage
`default_nettype wire

// [core/wpf_regs.sv]
// Wake packet filter configuration and status register bank
`default_nettype none
module wpf_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port from station management
  input wire logic [15:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // Receive filter results, valid with rxFrameEnd
  input wire logic rxFrameEnd,
  input wire logic rxMagicMatch,
  input wire logic rxCrcBad,
  input wire logic rxSfdMissing,
  input wire logic rxPasswordBad,
  // Other interrupt source sharing the interrupt line, chosen by the status route bit
  input wire logic dataPolarityIrq,
  // Strap pin for the interrupt enable
  input wire logic strapIrqOn,
  // Outputs
  output logic wakeOut,
  output logic sharedIrq,
  output logic wakeDetectOn,
  output logic secureCheckOn,
  output logic bitMaskFlag,
  output logic [15:0] matchAddrData1
);
  logic crcGate;
  logic [1:0] pulseSel;
  logic levelMode;
  logic frameIrqOn;
  logic strapDone;
  logic strapSync;
  logic route;
  logic [wpf_pkg::FLAG_COUNT-1:0] flags;
  logic [wpf_pkg::FLAG_COUNT-1:0] flagSet;
  logic cfgWr;
  logic stsWr;
  logic madWr;
  logic stsRd;
  logic frameOk;
  logic crcBlock;
  logic pwdFail;
  logic wakeEvent;
  logic [15:0] rdWord;

  wpf_ind_if indBus();

  function automatic logic hit(input logic [15:0] addr,
      input logic [15:0] off);
    hit = (addr == off);
  endfunction

  assign cfgWr = regWrEn && hit(regAddr, wpf_pkg::CFG_ADDR);
  assign stsWr = regWrEn && hit(regAddr, wpf_pkg::STS_ADDR);
  assign madWr = regWrEn && hit(regAddr, wpf_pkg::MAD1_ADDR);
  assign stsRd = regRdEn && hit(regAddr, wpf_pkg::STS_ADDR);

  // Configuration fields
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      crcGate <= wpf_pkg::CFG_RESET[wpf_pkg::CFG_CRC_GATE];
      pulseSel <= wpf_pkg::CFG_RESET[wpf_pkg::CFG_PSEL_HI:
        wpf_pkg::CFG_PSEL_LO];
      levelMode <= wpf_pkg::CFG_RESET[wpf_pkg::CFG_STYLE];
      wakeDetectOn <= wpf_pkg::CFG_RESET[wpf_pkg::CFG_DETECT];
      bitMaskFlag <= wpf_pkg::CFG_RESET[wpf_pkg::CFG_MASK_FLAG];
      secureCheckOn <= wpf_pkg::CFG_RESET[wpf_pkg::CFG_SECURE];
    end else if (cfgWr) begin
      crcGate <= regWrData[wpf_pkg::CFG_CRC_GATE];
      pulseSel <= regWrData[wpf_pkg::CFG_PSEL_HI:
        wpf_pkg::CFG_PSEL_LO];
      levelMode <= regWrData[wpf_pkg::CFG_STYLE];
      wakeDetectOn <= regWrData[wpf_pkg::CFG_DETECT];
      bitMaskFlag <= regWrData[wpf_pkg::CFG_MASK_FLAG];
      secureCheckOn <= regWrData[wpf_pkg::CFG_SECURE];
    end
  end

  // Strap is caught once after release; an early write still wins
  wpf_sync2 strapSyncInst (
    .clk_sys(clk_sys),
    .din(strapIrqOn),
    .dout(strapSync)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      frameIrqOn <= wpf_pkg::CFG_RESET[wpf_pkg::CFG_IRQ_ON];
      strapDone <= 1'b0;
    end else begin
      strapDone <= 1'b1;
      if (cfgWr) begin
        frameIrqOn <= regWrData[wpf_pkg::CFG_IRQ_ON];
      end else if (!strapDone) begin
        frameIrqOn <= strapSync;
      end
    end
  end

  // Turning wake on overrides a same-cycle status write
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      route <= wpf_pkg::STS_RESET[wpf_pkg::STS_ROUTE];
    end else if (cfgWr && regWrData[wpf_pkg::CFG_DETECT]) begin
      route <= 1'b1;
    end else if (stsWr) begin
      route <= regWrData[wpf_pkg::STS_ROUTE];
    end
  end

  assign frameOk = rxFrameEnd && wakeDetectOn;
  assign crcBlock = crcGate && rxCrcBad;
  assign pwdFail = secureCheckOn && rxPasswordBad;
  assign wakeEvent = frameOk && rxMagicMatch && !crcBlock && !pwdFail;

  always_comb begin
    flagSet = '0;
    flagSet[wpf_pkg::FLAG_SEEN] = wakeEvent;
    flagSet[wpf_pkg::FLAG_PWD] = frameOk && rxMagicMatch && pwdFail &&
      !crcBlock;
    flagSet[wpf_pkg::FLAG_CRC] = frameOk && rxCrcBad;
    flagSet[wpf_pkg::FLAG_SFD] = frameOk && rxSfdMissing;
  end

  // Sticky flags, cleared by a status read; a new event wins the race
  for (genvar i = 0; i < wpf_pkg::FLAG_COUNT; i++) begin : gFlag
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        flags[i] <= 1'b0;
      end else if (flagSet[i]) begin
        flags[i] <= 1'b1;
      end else if (stsRd) begin
        flags[i] <= 1'b0;
      end
    end
  end

  // Shared interrupt line, one cycle per wake event; the polarity route copies dataPolarityIrq a cycle late
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sharedIrq <= 1'b0;
    end else begin
      sharedIrq <= route ? (wakeEvent && frameIrqOn) :
        dataPolarityIrq;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      matchAddrData1 <= wpf_pkg::MAD1_RESET;
    end else if (madWr) begin
      matchAddrData1 <= regWrData;
    end
  end

  // Reserved bits and the self-clearing bit read as zero
  always_comb begin
    rdWord = '0;
    if (hit(regAddr, wpf_pkg::CFG_ADDR)) begin
      rdWord[wpf_pkg::CFG_CRC_GATE] = crcGate;
      rdWord[wpf_pkg::CFG_PSEL_HI:wpf_pkg::CFG_PSEL_LO] = pulseSel;
      rdWord[wpf_pkg::CFG_STYLE] = levelMode;
      rdWord[wpf_pkg::CFG_DETECT] = wakeDetectOn;
      rdWord[wpf_pkg::CFG_MASK_FLAG] = bitMaskFlag;
      rdWord[wpf_pkg::CFG_SECURE] = secureCheckOn;
      rdWord[wpf_pkg::CFG_IRQ_ON] = frameIrqOn;
    end else if (hit(regAddr, wpf_pkg::STS_ADDR)) begin
      rdWord[wpf_pkg::STS_ROUTE] = route;
      rdWord[wpf_pkg::STS_SFD] = flags[wpf_pkg::FLAG_SFD];
      rdWord[wpf_pkg::STS_CRC] = flags[wpf_pkg::FLAG_CRC];
      rdWord[wpf_pkg::STS_PWD] = flags[wpf_pkg::FLAG_PWD];
      rdWord[wpf_pkg::STS_SEEN] = flags[wpf_pkg::FLAG_SEEN];
    end else if (hit(regAddr, wpf_pkg::MAD1_ADDR)) begin
      rdWord = matchAddrData1;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdData <= wpf_pkg::RD_RESET;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= rdWord;
      end
    end
  end

  assign indBus.trigger = wakeEvent;
  assign indBus.levelMode = levelMode;
  assign indBus.pulseSel = pulseSel;
  assign indBus.levelClear = cfgWr && regWrData[wpf_pkg::CFG_LVL_CLR];

  wpf_indicator indInst (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ind(indBus.ind)
  );

  assign wakeOut = indBus.wakePin;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_crc_gate_block: assert property (
    rxFrameEnd && crcGate && rxCrcBad && !flags[wpf_pkg::FLAG_SEEN]
    |=> !flags[wpf_pkg::FLAG_SEEN] && !$rose(wakeOut))
    else $error("bad CRC frame raised a wake indication");

  chk_detect_off: assert property (
    !wakeDetectOn && !flags[wpf_pkg::FLAG_SEEN]
    |=> !flags[wpf_pkg::FLAG_SEEN])
    else $error("wake flag set while detection off");

  chk_secure_flag: assert property (
    rxFrameEnd && wakeDetectOn && rxMagicMatch && secureCheckOn &&
    rxPasswordBad && !rxCrcBad
    |=> flags[wpf_pkg::FLAG_PWD])
    else $error("bad password not flagged");

  chk_pwd_clean: assert property (
    !flags[wpf_pkg::FLAG_PWD] && !(rxFrameEnd && rxPasswordBad)
    |=> !flags[wpf_pkg::FLAG_PWD])
    else $error("password flag set without a bad password");

  chk_irq_enable: assert property (
    rxFrameEnd && wakeDetectOn && rxMagicMatch && !rxCrcBad &&
    !rxPasswordBad && frameIrqOn && route
    |=> sharedIrq)
    else $error("enabled wake interrupt missing");

  chk_irq_masked: assert property (
    route && !frameIrqOn |=> !sharedIrq)
    else $error("wake interrupt raised while disabled");

  chk_route_polarity: assert property (
    !route |=> sharedIrq == $past(dataPolarityIrq))
    else $error("polarity interrupt not routed");

  chk_auto_route: assert property (
    cfgWr && regWrData[wpf_pkg::CFG_DETECT] |=> route)
    else $error("enabling wake did not select wake route");

  chk_sfd_flag: assert property (
    rxFrameEnd && wakeDetectOn && rxSfdMissing
    |=> flags[wpf_pkg::FLAG_SFD])
    else $error("delimiter flag not set");

  chk_crc_flag: assert property (
    rxFrameEnd && wakeDetectOn && rxCrcBad |=> flags[wpf_pkg::FLAG_CRC])
    else $error("bad CRC flag not set");

  chk_seen_set: assert property (
    rxFrameEnd && wakeDetectOn && rxMagicMatch && !rxCrcBad &&
    !rxPasswordBad |=> flags[wpf_pkg::FLAG_SEEN])
    else $error("magic packet not reported");

  chk_flag_hold: assert property (
    flags[wpf_pkg::FLAG_CRC] && !stsRd |=> flags[wpf_pkg::FLAG_CRC])
    else $error("sticky flag lost without a read");

  chk_status_clear: assert property (
    stsRd && flagSet == '0 |=> flags == '0)
    else $error("status read did not clear the flags");

  chk_crc_gate_irq: assert property (
    rxFrameEnd && crcGate && rxCrcBad && route |=> !sharedIrq)
    else $error("bad CRC frame raised the wake interrupt");

  chk_sts_readback: assert property (
    stsRd |=> regRdData[wpf_pkg::STS_SEEN] == $past(flags[wpf_pkg::FLAG_SEEN]))
    else $error("status read lost the magic packet bit");

  chk_strap_load: assert property (
    $rose(strapDone) && !$past(cfgWr) |-> frameIrqOn == $past(strapSync))
    else $error("interrupt enable did not take the strap");

  cov_wake_irq: cover property (route && sharedIrq && wakeOut);
  cov_route_swap: cover property (!route ##1 route);
  cov_status_clear: cover property (stsRd && flags != '0 ##1 flags == '0);
endmodule
`default_nettype wire

// [core/wpf_sync2.sv]
// Two flip-flop synchroniser for a pin level
`default_nettype none
module wpf_sync2 (
  // Clock
  input wire logic clk_sys,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta;

  // No reset: runs through reset so the level is settled at release
  always_ff @(posedge clk_sys) begin
    meta <= din;
    dout <= meta;
  end
endmodule
`default_nettype wire

// [verification/tb_wake_packet_filter_regs.sv]
// Self-checking bench for the wake packet filter register bank
`default_nettype none
module tb_wake_packet_filter_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] regAddr, regWrData, regRdData, matchAddrData1;
  logic regWrEn, regRdEn, regRdValid, rxFrameEnd, rxMagicMatch;
  logic rxCrcBad, rxSfdMissing, rxPasswordBad, dataPolarityIrq;
  logic strapIrqOn, wakeOut, sharedIrq, wakeDetectOn, secureCheckOn;
  logic bitMaskFlag;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 32'ha9ad1553;
  // Reference model state
  int mCfg = 16'h1081;
  int mRoute = 1;
  int mFlags = 0;
  int mMad = 0;
  logic [15:0] d;
  logic v;

  always #5 clk_sys = ~clk_sys;

  wpf_regs uut (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .rxFrameEnd(rxFrameEnd), .rxMagicMatch(rxMagicMatch),
    .rxCrcBad(rxCrcBad), .rxSfdMissing(rxSfdMissing),
    .rxPasswordBad(rxPasswordBad), .dataPolarityIrq(dataPolarityIrq),
    .strapIrqOn(strapIrqOn), .wakeOut(wakeOut), .sharedIrq(sharedIrq),
    .wakeDetectOn(wakeDetectOn), .secureCheckOn(secureCheckOn),
    .bitMaskFlag(bitMaskFlag), .matchAddrData1(matchAddrData1));

  wpf_host_model host (.clk_sys(clk_sys), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid));

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic mWr(input logic [15:0] a, input logic [15:0] wd);
    if (a == wpf_pkg::CFG_ADDR) begin
      mCfg = wd & 16'h17E1;
      if (wd[7]) mRoute = 1;
    end
    if (a == wpf_pkg::STS_ADDR) mRoute = wd[12];
    if (a == wpf_pkg::MAD1_ADDR) mMad = wd;
    host.wr(a, wd);
  endtask

  // Status read returns then clears the sticky flags
  task automatic mRd(input logic [15:0] a);
    int e;
    e = 0;
    if (a == wpf_pkg::CFG_ADDR) e = mCfg;
    if (a == wpf_pkg::MAD1_ADDR) e = mMad;
    if (a == wpf_pkg::STS_ADDR) begin
      e = (mRoute << 12) | mFlags;
      mFlags = 0;
    end
    host.rd(a, d, v);
    chk(16'(v), 16'h0001);
    chk(d, 16'(e));
  endtask

  task automatic frame(input logic mg, input logic cb, input logic sm,
      input logic pb);
    logic seen;
    int n;
    int cnt;
    seen = mCfg[7] & mg & !(mCfg[12] & cb) & !(mCfg[5] & pb);
    if (mCfg[7]) mFlags |= {sm, cb, mg & mCfg[5] & pb & !(mCfg[12] & cb),
      4'h0, seen};
    @(posedge clk_sys);
    #1;
    {rxFrameEnd, rxMagicMatch, rxCrcBad, rxSfdMissing} = {1'b1, mg, cb, sm};
    rxPasswordBad = pb;
    @(posedge clk_sys);
    #1;
    rxFrameEnd = 1'b0;
    {rxMagicMatch, rxCrcBad, rxSfdMissing, rxPasswordBad} = 4'($random(seed));
    chk(16'(sharedIrq), 16'(mRoute & mCfg[0] & seen));
    chk(16'(wakeOut), 16'(seen));
    if (seen && !mCfg[8]) begin
      n = ((8 << mCfg[10:9]) * wpf_pkg::SYS_CLK_MHZ
        + wpf_pkg::REF_CLK_MHZ - 1) / wpf_pkg::REF_CLK_MHZ;
      cnt = 0;
      while (wakeOut === 1'b1 && cnt < 100) begin
        cnt++;
        @(posedge clk_sys);
        #1;
      end
      chk(16'(cnt), 16'(n));
    end
  endtask

  initial begin
    {rxFrameEnd, rxMagicMatch, rxCrcBad, rxSfdMissing} = 4'h0;
    rxPasswordBad = 1'b0;
    dataPolarityIrq = 1'b0;
    strapIrqOn = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(16'(wakeDetectOn), 16'h0001);
    for (int a = 16'h04A0; a < 16'h04A4; a++) mRd(16'(a));
    $display("test reset values done");
    // Random data, an unmapped place and read-only bits
    for (int i = 0; i < 4; i++) begin
      for (int a = 16'h04A0; a < 16'h04A4; a++)
        mWr(16'(a), 16'($random(seed)));
      for (int a = 16'h04A0; a < 16'h04A4; a++) mRd(16'(a));
      chk(16'(bitMaskFlag), 16'(mCfg[6]));
      chk(matchAddrData1, 16'(mMad));
    end
    mWr(wpf_pkg::CFG_ADDR, 16'h1081);
    $display("test register access done");
    for (int s = 0; s < 4; s++) begin
      mWr(wpf_pkg::CFG_ADDR, 16'(16'h1081 | (s << 9)));
      frame(1'b1, 1'b0, 1'b0, 1'b0);
      mRd(wpf_pkg::STS_ADDR);
      mRd(wpf_pkg::STS_ADDR);
    end
    $display("test pulse lengths done");
    frame(1'b1, 1'b1, 1'b0, 1'b0);
    mRd(wpf_pkg::STS_ADDR);
    mWr(wpf_pkg::CFG_ADDR, 16'h0081);
    frame(1'b1, 1'b1, 1'b0, 1'b0);
    mRd(wpf_pkg::STS_ADDR);
    mWr(wpf_pkg::CFG_ADDR, 16'h10A1);
    chk(16'(secureCheckOn), 16'h0001);
    frame(1'b1, 1'b0, 1'b0, 1'b1);
    mRd(wpf_pkg::STS_ADDR);
    frame(1'b1, 1'b0, 1'b0, 1'b0);
    mRd(wpf_pkg::STS_ADDR);
    frame(1'b0, 1'b0, 1'b1, 1'b0);
    mRd(wpf_pkg::STS_ADDR);
    $display("test frame flags done");
    mWr(wpf_pkg::CFG_ADDR, 16'h1001);
    chk(16'(wakeDetectOn), 16'h0000);
    frame(1'b1, 1'b1, 1'b1, 1'b1);
    mRd(wpf_pkg::STS_ADDR);
    mWr(wpf_pkg::CFG_ADDR, 16'h1080);
    frame(1'b1, 1'b0, 1'b0, 1'b0);
    mRd(wpf_pkg::STS_ADDR);
    $display("test enables done");
    mWr(wpf_pkg::STS_ADDR, 16'h0000);
    mRd(wpf_pkg::STS_ADDR);
    for (int i = 0; i < 16; i++) begin
      dataPolarityIrq = 1'($random(seed));
      @(posedge clk_sys);
      #1;
      chk(16'(sharedIrq), 16'(dataPolarityIrq));
    end
    dataPolarityIrq = 1'b0;
    mWr(wpf_pkg::CFG_ADDR, 16'h1081);
    mRd(wpf_pkg::STS_ADDR);
    $display("test interrupt route done");
    mWr(wpf_pkg::CFG_ADDR, 16'h1181);
    frame(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (20) @(posedge clk_sys);
    #1;
    chk(16'(wakeOut), 16'h0001);
    mWr(wpf_pkg::CFG_ADDR, 16'h1981);
    @(posedge clk_sys);
    #1;
    chk(16'(wakeOut), 16'h0000);
    mRd(wpf_pkg::CFG_ADDR);
    $display("test level mode done");
    // Second reset with the strap low: interrupt enable follows it
    strapIrqOn = 1'b0;
    reset_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    mCfg = 16'h1080;
    mRoute = 1;
    mFlags = 0;
    mMad = 0;
    for (int a = 16'h04A0; a < 16'h04A3; a++) mRd(16'(a));
    $display("test strap reset done");
    end_sim();
  end
endmodule
`default_nettype wire

// [verification/wpf_host_model.sv]
// Station management host model driving the register strobe port
`default_nettype none
module wpf_host_model (
  // Clock
  input wire logic clk_sys,
  // Strobe port toward the register bank
  output logic [15:0] regAddr,
  output logic regWrEn,
  output logic regRdEn,
  output logic [15:0] regWrData,
  // Read answer
  input wire logic [15:0] regRdData,
  input wire logic regRdValid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regAddr = 16'h0000;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 16'h0000;
  end
  // Released lines flip so a stale value never looks valid
  task automatic drop();
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = ~regAddr;
    regWrData = ~regWrData;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk_sys);
    #1;
    drop();
  endtask
  // Answer is registered: taken one cycle after the strobe edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d,
      output logic v);
    @(posedge clk_sys);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk_sys);
    #1;
    drop();
    d = regRdData;
    v = regRdValid;
  endtask
endmodule
`default_nettype wire
